// ===== design/aitg_fifo.sv
`timescale 1ns/1ns
module aitg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       reset_i,
	// Fill side.
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	// Drain side.
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [WIDTH-1:0]                out_data_o,
	// Fill level.
	output logic [$clog2(DEPTH+1)-1:0]      count_o
);
	import aitg_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]       mem_r [DEPTH];
	logic [AW-1:0]          wp_r;
	logic [AW-1:0]          wp_nxt;
	logic [AW-1:0]          rp_r;
	logic [AW-1:0]          rp_nxt;
	logic [$clog2(DEPTH+1)-1:0] cnt_r;
	logic [$clog2(DEPTH+1)-1:0] cnt_nxt;
	logic                   push;
	logic                   pop;

	// ==========================================================================
	// Pointer and level update.
	always_comb begin
		push    = in_valid_i && in_ready_o;
		pop     = out_valid_o && out_ready_i;
		wp_nxt  = push ? AW'((32'(wp_r) + 1) % DEPTH) : wp_r;
		rp_nxt  = pop ? AW'((32'(rp_r) + 1) % DEPTH) : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	assign in_ready_o  = (32'(cnt_r) != DEPTH);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];
	assign count_o     = cnt_r;
endmodule

// ===== design/aitg_link_if.sv
`timescale 1ns/1ns
interface aitg_link_if;
	// Request frame from source to sink.
	logic       req_valid;
	logic [7:0] req_data;
	logic       req_last;
	logic       req_ready;
	// Read reply bytes from sink to source.
	logic       rep_valid;
	logic [7:0] rep_data;
	logic       rep_last;
	logic       rep_ready;

	modport src (output req_valid, req_data, req_last, input req_ready,
		input rep_valid, rep_data, rep_last, output rep_ready);
	modport snk (input req_valid, req_data, req_last, output req_ready,
		output rep_valid, rep_data, rep_last, input rep_ready);
endinterface

// ===== design/aitg_pkg.sv
package aitg_pkg;

	// ==========================================================================
	// Register map.
	localparam logic [11:0] OFS_REQ_CTRL   = 12'h100;
	localparam logic [11:0] OFS_WR_FIFO    = 12'h104;
	localparam logic [11:0] OFS_TGT_ADDR   = 12'h108;
	localparam logic [11:0] OFS_STATUS     = 12'h10C;
	localparam logic [11:0] OFS_REPLY_DATA = 12'h110;

	// ==========================================================================
	// Request control word fields.
	localparam int LEN_LSB = 0;
	localparam int LEN_W   = 4;
	localparam int CMD_LSB = 8;
	localparam int CMD_W   = 4;

	// ==========================================================================
	// Command codes; bit 2 is the continue flag, bit 0 the read direction.
	localparam logic [3:0] CMD_WRITE      = 4'h0;
	localparam logic [3:0] CMD_WRITE_CONT = 4'h4;
	localparam logic [3:0] CMD_READ       = 4'h1;
	localparam logic [3:0] CMD_READ_CONT  = 4'h5;
	localparam int         CMD_CONT_BIT   = 2;
	localparam int         CMD_RD_BIT     = 0;

	// ==========================================================================
	// Status register fields and reset values.
	localparam int         ST_BUSY_BIT  = 0;
	localparam int         ST_DONE_BIT  = 1;
	localparam int         ST_RCNT_LSB  = 8;
	localparam logic [7:0] TGT_ADDR_RST = 8'h00;

	// ==========================================================================
	// Sizes.
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 16;

	// ==========================================================================
	// Bridged bus operations presented by the sink.
	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_START = 3'h1,
		OP_DEVAD = 3'h2,
		OP_WDATA = 3'h3,
		OP_RDATA = 3'h4,
		OP_STOP  = 3'h5
	} aitg_op_t;

endpackage

// ===== design/aitg_sink.sv
`timescale 1ns/1ns
module aitg_sink (
	// Clock and reset.
	input  wire logic      clk_i,
	input  wire logic      reset_i,
	// Link from the source.
	aitg_link_if.snk       link,
	// Bridged bus operations.
	output logic           op_valid_o,
	output aitg_pkg::aitg_op_t op_code_o,
	output logic [7:0]     op_data_o,
	input  wire logic      op_ready_i,
	input  wire logic [7:0] rdata_i,
	output logic           bus_open_o
);
	import aitg_pkg::*;

	typedef enum logic [9:0] {
		K_CMD   = 10'h001,
		K_ADDR  = 10'h002,
		K_LEN   = 10'h004,
		K_START = 10'h008,
		K_DEVAD = 10'h010,
		K_WGET  = 10'h020,
		K_WPUT  = 10'h040,
		K_RGET  = 10'h080,
		K_RREP  = 10'h100,
		K_STOP  = 10'h200
	} aitg_snk_state_t;

	aitg_snk_state_t st_r;
	aitg_snk_state_t st_nxt;
	logic [3:0]      cmd_r;
	logic [3:0]      cmd_nxt;
	logic [7:0]      adr_r;
	logic [7:0]      adr_nxt;
	logic [3:0]      cnt_r;
	logic [3:0]      cnt_nxt;
	logic [7:0]      dat_r;
	logic [7:0]      dat_nxt;
	logic            open_r;
	logic            open_nxt;
	logic [7:0]      badr_r;
	logic [7:0]      badr_nxt;
	logic            brd_r;
	logic            brd_nxt;
	logic            fin;

	// ==========================================================================
	// Frame decode and bus sequencing.
	always_comb begin
		st_nxt   = st_r;
		cmd_nxt  = cmd_r;
		adr_nxt  = adr_r;
		cnt_nxt  = cnt_r;
		dat_nxt  = dat_r;
		open_nxt = open_r;
		badr_nxt = badr_r;
		brd_nxt  = brd_r;
		fin      = 1'b0;
		link.req_ready = st_r == K_CMD || st_r == K_ADDR || st_r == K_LEN
			|| st_r == K_WGET;
		case (st_r)
			K_CMD: begin
				if (link.req_valid) begin
					cmd_nxt = link.req_data[3:0];
					st_nxt  = K_ADDR;
				end
			end
			K_ADDR: begin
				if (link.req_valid) begin
					adr_nxt = link.req_data;
					st_nxt  = K_LEN;
				end
			end
			K_LEN: begin
				if (link.req_valid) begin
					cnt_nxt = link.req_data[3:0];
					if (!open_r || adr_r != badr_r || cmd_r[CMD_RD_BIT] != brd_r) begin
						st_nxt = K_START;
					end else if (link.req_data[3:0] == '0) begin
						fin = 1'b1;
					end else begin
						st_nxt = cmd_r[CMD_RD_BIT] ? K_RGET : K_WGET;
					end
				end
			end
			K_START: begin
				if (op_ready_i) begin
					st_nxt = K_DEVAD;
				end
			end
			K_DEVAD: begin
				if (op_ready_i) begin
					open_nxt = 1'b1;
					badr_nxt = adr_r;
					brd_nxt  = cmd_r[CMD_RD_BIT];
					if (cnt_r == '0) begin
						fin = 1'b1;
					end else begin
						st_nxt = cmd_r[CMD_RD_BIT] ? K_RGET : K_WGET;
					end
				end
			end
			K_WGET: begin
				if (link.req_valid) begin
					dat_nxt = link.req_data;
					st_nxt  = K_WPUT;
				end
			end
			K_WPUT: begin
				if (op_ready_i) begin
					cnt_nxt = cnt_r - 1'b1;
					if (cnt_r == 4'h1) begin
						fin = 1'b1;
					end else begin
						st_nxt = K_WGET;
					end
				end
			end
			K_RGET: begin
				if (op_ready_i) begin
					dat_nxt = rdata_i;
					st_nxt  = K_RREP;
				end
			end
			K_RREP: begin
				if (link.rep_ready) begin
					cnt_nxt = cnt_r - 1'b1;
					if (cnt_r == 4'h1) begin
						fin = 1'b1;
					end else begin
						st_nxt = K_RGET;
					end
				end
			end
			K_STOP: begin
				if (op_ready_i) begin
					open_nxt = 1'b0;
					st_nxt   = K_CMD;
				end
			end
			default: begin
				st_nxt = K_CMD;
			end
		endcase
		if (fin) begin
			st_nxt = cmd_r[CMD_CONT_BIT] ? K_CMD : K_STOP;
		end
	end

	always_comb begin
		op_valid_o = 1'b1;
		op_data_o  = dat_r;
		case (st_r)
			K_START: begin
				op_code_o = OP_START;
			end
			K_DEVAD: begin
				op_code_o = OP_DEVAD;
				op_data_o = {adr_r[6:0], cmd_r[CMD_RD_BIT]};
			end
			K_WPUT: begin
				op_code_o = OP_WDATA;
			end
			K_RGET: begin
				op_code_o = OP_RDATA;
			end
			K_STOP: begin
				op_code_o = OP_STOP;
			end
			default: begin
				op_code_o  = OP_NONE;
				op_valid_o = 1'b0;
			end
		endcase
		link.rep_valid = st_r == K_RREP;
		link.rep_data  = dat_r;
		link.rep_last  = cnt_r == 4'h1;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r   <= K_CMD;
			cmd_r  <= '0;
			adr_r  <= '0;
			cnt_r  <= '0;
			dat_r  <= '0;
			open_r <= 1'b0;
			badr_r <= '0;
			brd_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cmd_r  <= cmd_nxt;
			adr_r  <= adr_nxt;
			cnt_r  <= cnt_nxt;
			dat_r  <= dat_nxt;
			open_r <= open_nxt;
			badr_r <= badr_nxt;
			brd_r  <= brd_nxt;
		end
	end

	assign bus_open_o = open_r;
endmodule

// ===== design/aitg_source.sv
// Summary of operation
// - Host loads target address at 0x108 first.
// - Host loads write payload at 0x104 beforehand.
// - Host writes command and length to 0x100.
// - Control write launches request with stored values.
// - Continued write frames header, data, end; bus open.
// - Without continue flag, transfer ends with stop.
// - New or idle address gets start, address, direction.
// - Continued read frames header only, bus open.
// - Read needs only address and command writes.
// - Low four command bits give byte length.
// - Command bits 11:8 select write, read, continue.
// - Reply bytes via one register, 16-deep FIFO.
// - Continue keeps bus held, otherwise returns idle.
`timescale 1ns/1ns
module aitg_source #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic [31:0]      prdata_o,
	// Link to the sink.
	aitg_link_if.src         link
);
	import aitg_pkg::*;

	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_CMD  = 6'h02,
		S_ADDR = 6'h04,
		S_LEN  = 6'h08,
		S_DATA = 6'h10,
		S_WAIT = 6'h20
	} aitg_src_state_t;

	aitg_src_state_t    state_r;
	aitg_src_state_t    state_nxt;
	logic [ADDR_W-1:0]  addr_r;
	logic [ADDR_W-1:0]  addr_nxt;
	logic [CMD_W-1:0]   cmd_r;
	logic [CMD_W-1:0]   cmd_nxt;
	logic [LEN_W-1:0]   len_r;
	logic [LEN_W-1:0]   len_nxt;
	logic [LEN_W-1:0]   cnt_r;
	logic [LEN_W-1:0]   cnt_nxt;
	logic               done_r;
	logic               done_nxt;
	logic               acc;
	logic               wr_acc;
	logic               rd_acc;
	logic               mapped;
	logic               cmd_ok;
	logic               finish;
	logic [CMD_W-1:0]   wcmd;
	logic               wf_in_valid;
	logic               wf_in_ready;
	logic               wf_out_valid;
	logic               wf_out_ready;
	logic [7:0]         wf_out_data;
	logic               rf_in_ready;
	logic               rf_out_valid;
	logic               rf_out_ready;
	logic [7:0]         rf_out_data;
	logic [$clog2(FIFO_DEPTH+1)-1:0] rf_count;

	// ==========================================================================
	// Payload and reply buffers.
	aitg_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.in_valid_i (wf_in_valid),
		.in_ready_o (wf_in_ready),
		.in_data_i  (pwdata_i[7:0]),
		.out_valid_o(wf_out_valid),
		.out_ready_i(wf_out_ready),
		.out_data_o (wf_out_data),
		.count_o    ()
	);

	aitg_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_reply_fifo (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.in_valid_i (link.rep_valid && state_r == S_WAIT),
		.in_ready_o (rf_in_ready),
		.in_data_i  (link.rep_data),
		.out_valid_o(rf_out_valid),
		.out_ready_i(rf_out_ready),
		.out_data_o (rf_out_data),
		.count_o    (rf_count)
	);

	// ==========================================================================
	// APB decode.
	always_comb begin
		acc      = psel_i && penable_i;
		mapped   = paddr_i == OFS_REQ_CTRL || paddr_i == OFS_WR_FIFO
			|| paddr_i == OFS_TGT_ADDR || paddr_i == OFS_STATUS
			|| paddr_i == OFS_REPLY_DATA;
		wcmd     = pwdata_i[CMD_LSB +: CMD_W];
		cmd_ok   = wcmd == CMD_WRITE || wcmd == CMD_WRITE_CONT
			|| wcmd == CMD_READ || wcmd == CMD_READ_CONT;
		pready_o = !(psel_i && pwrite_i && paddr_i == OFS_WR_FIFO) || wf_in_ready;
		pslverr_o = acc && !mapped;
		wr_acc   = acc && pready_o && pwrite_i;
		rd_acc   = acc && pready_o && !pwrite_i;
		wf_in_valid  = wr_acc && paddr_i == OFS_WR_FIFO;
		rf_out_ready = rd_acc && paddr_i == OFS_REPLY_DATA;
		prdata_o = '0;
		if (psel_i && !pwrite_i) begin
			case (paddr_i)
				OFS_TGT_ADDR: begin
					prdata_o = 32'(addr_r);
				end
				OFS_STATUS: begin
					prdata_o[ST_BUSY_BIT] = state_r != S_IDLE;
					prdata_o[ST_DONE_BIT] = done_r;
					prdata_o[ST_RCNT_LSB +: $bits(rf_count)] = rf_count;
				end
				OFS_REPLY_DATA: begin
					prdata_o = rf_out_valid ? 32'(rf_out_data) : '0;
				end
				default: begin
					prdata_o = '0;
				end
			endcase
		end
	end

	// ==========================================================================
	// Request framing.
	always_comb begin
		state_nxt      = state_r;
		addr_nxt       = addr_r;
		cmd_nxt        = cmd_r;
		len_nxt        = len_r;
		cnt_nxt        = cnt_r;
		finish         = 1'b0;
		link.req_valid = 1'b0;
		link.req_data  = '0;
		link.req_last  = 1'b0;
		link.rep_ready = 1'b0;
		wf_out_ready   = 1'b0;
		if (wr_acc && paddr_i == OFS_TGT_ADDR) begin
			addr_nxt = pwdata_i[ADDR_W-1:0];
		end
		case (state_r)
			S_IDLE: begin
				if (wr_acc && paddr_i == OFS_REQ_CTRL && cmd_ok) begin
					cmd_nxt   = wcmd;
					len_nxt   = pwdata_i[LEN_LSB +: LEN_W];
					cnt_nxt   = pwdata_i[LEN_LSB +: LEN_W];
					state_nxt = S_CMD;
				end
			end
			S_CMD: begin
				link.req_valid = 1'b1;
				link.req_data  = 8'(cmd_r);
				if (link.req_ready) begin
					state_nxt = S_ADDR;
				end
			end
			S_ADDR: begin
				link.req_valid = 1'b1;
				link.req_data  = 8'(addr_r);
				if (link.req_ready) begin
					state_nxt = S_LEN;
				end
			end
			S_LEN: begin
				link.req_valid = 1'b1;
				link.req_data  = 8'(len_r);
				link.req_last  = cmd_r[CMD_RD_BIT] || len_r == '0;
				if (link.req_ready) begin
					if (len_r == '0) begin
						finish    = 1'b1;
						state_nxt = S_IDLE;
					end else if (cmd_r[CMD_RD_BIT]) begin
						state_nxt = S_WAIT;
					end else begin
						state_nxt = S_DATA;
					end
				end
			end
			S_DATA: begin
				link.req_valid = wf_out_valid;
				link.req_data  = wf_out_data;
				link.req_last  = cnt_r == 4'h1;
				wf_out_ready   = link.req_ready;
				if (wf_out_valid && link.req_ready) begin
					cnt_nxt = cnt_r - 1'b1;
					if (cnt_r == 4'h1) begin
						finish    = 1'b1;
						state_nxt = S_IDLE;
					end
				end
			end
			S_WAIT: begin
				link.rep_ready = rf_in_ready;
				if (link.rep_valid && rf_in_ready && link.rep_last) begin
					finish    = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
		done_nxt = done_r;
		if (wr_acc && paddr_i == OFS_STATUS && pwdata_i[ST_DONE_BIT]) begin
			done_nxt = 1'b0;
		end
		if (finish) begin
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= S_IDLE;
			addr_r  <= ADDR_W'(TGT_ADDR_RST);
			cmd_r   <= '0;
			len_r   <= '0;
			cnt_r   <= '0;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			addr_r  <= addr_nxt;
			cmd_r   <= cmd_nxt;
			len_r   <= len_nxt;
			cnt_r   <= cnt_nxt;
			done_r  <= done_nxt;
		end
	end
endmodule

// ===== verif/aitg_asserts.sv
`timescale 1ns/1ns
module aitg_asserts (
	// Clock and reset.
	input wire logic       clk_i,
	input wire logic       reset_i,
	// Link signals.
	input wire logic       req_valid,
	input wire logic [7:0] req_data,
	input wire logic       req_last,
	input wire logic       req_ready,
	input wire logic       rep_valid,
	input wire logic [7:0] rep_data,
	input wire logic       rep_last,
	input wire logic       rep_ready
);
	logic [4:0] beat_r, beat_nxt, rcnt_r, rcnt_nxt;
	logic [3:0] len_r, len_nxt, cur_len;
	logic       rd_r, rd_nxt, pend_r, pend_nxt, rq, rp;

	// ==========================================================================
	// Frame tracking.
	always_comb begin
		rq = req_valid && req_ready;
		rp = rep_valid && rep_ready;
		cur_len = (beat_r == 5'h2) ? req_data[3:0] : len_r;
		beat_nxt = beat_r;
		rd_nxt = rd_r;
		len_nxt = len_r;
		pend_nxt = pend_r;
		rcnt_nxt = rcnt_r;
		if (rq) begin
			beat_nxt = req_last ? 5'h0 : beat_r + 5'h1;
			if (beat_r == 5'h0) rd_nxt = req_data[0];
			if (beat_r == 5'h2) len_nxt = req_data[3:0];
			if (req_last && rd_r && beat_r == 5'h2 && req_data[3:0] != 4'h0) pend_nxt = 1'b1;
		end
		if (rp) begin
			rcnt_nxt = rep_last ? 5'h0 : rcnt_r + 5'h1;
			if (rep_last) pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			beat_r <= 5'h0;
			rcnt_r <= 5'h0;
			len_r <= 4'h0;
			rd_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			beat_r <= beat_nxt;
			rcnt_r <= rcnt_nxt;
			len_r <= len_nxt;
			rd_r <= rd_nxt;
			pend_r <= pend_nxt;
		end
	end

	// ==========================================================================
	// Properties.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	req_hold_a: assert property (req_valid && !req_ready |=>
		req_valid && $stable(req_data) && $stable(req_last)) else $error("request beat changed");
	rep_hold_a: assert property (rep_valid && !rep_ready |=>
		rep_valid && $stable(rep_data) && $stable(rep_last)) else $error("reply beat changed");
	cmd_code_a: assert property (rq && beat_r == 5'h0 |->
		req_data inside {8'h00, 8'h04, 8'h01, 8'h05}) else $error("bad command byte");
	len_byte_a: assert property (rq && beat_r == 5'h2 |-> req_data[7:4] == 4'h0)
		else $error("bad length byte");
	rd_frame_a: assert property (rq && beat_r == 5'h2 && rd_r |-> req_last)
		else $error("read frame not ended");
	wr_end_a: assert property (rq && !rd_r && beat_r >= 5'h2 |->
		req_last == (beat_r == {1'b0, cur_len} + 5'h2)) else $error("write frame length");
	one_cmd_a: assert property (req_valid && beat_r == 5'h0 |-> !pend_r)
		else $error("command while read open");
	rep_count_a: assert property (rp && rep_last |-> rcnt_r + 5'h1 == {1'b0, len_r})
		else $error("reply count");
	rep_gate_a: assert property (rep_valid |-> pend_r)
		else $error("reply without read");

	cover property (rq && req_last && !rd_r);
	cover property (rp && rep_last);
	cover property (rep_valid && !rep_ready);
endmodule

// ===== verif/aitg_bench.sv
`timescale 1ns/1ns
module aitg_bench;
	import aitg_pkg::*;
	logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        op_valid, op_ready, bus_open;
	aitg_op_t    op_code;
	logic [7:0]  op_data, rdata, b;
	logic [10:0] exq[$];
	logic [7:0]  rdq[$];
	int          errors, n_checks;

	aitg_link_if lnk();
	aitg_source i_aitg_source (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .link(lnk));
	aitg_sink i_aitg_sink (.clk_i(clk_i), .reset_i(reset_i), .link(lnk),
		.op_valid_o(op_valid), .op_code_o(op_code), .op_data_o(op_data),
		.op_ready_i(op_ready), .rdata_i(rdata), .bus_open_o(bus_open));
	aitg_asserts i_aitg_asserts (.clk_i(clk_i), .reset_i(reset_i),
		.req_valid(lnk.req_valid), .req_data(lnk.req_data), .req_last(lnk.req_last),
		.req_ready(lnk.req_ready), .rep_valid(lnk.rep_valid), .rep_data(lnk.rep_data),
		.rep_last(lnk.rep_last), .rep_ready(lnk.rep_ready));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ==========================================================================
	// Shared tasks.
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task close_out;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task xfer(input logic [3:0] c, input logic [3:0] n, input logic [7:0] a, input bit hdr);
		apb(1'b1, OFS_TGT_ADDR, {24'h0, a});
		if (hdr) begin
			exq.push_back({OP_START, 8'h00});
			exq.push_back({OP_DEVAD, a[6:0], c[CMD_RD_BIT]});
		end
		for (int i = 0; i < n; i++) begin
			if (c[CMD_RD_BIT]) exq.push_back({OP_RDATA, 8'h00});
			else begin
				b = 8'($urandom);
				apb(1'b1, OFS_WR_FIFO, {24'h0, b});
				exq.push_back({OP_WDATA, b});
			end
		end
		if (!c[CMD_CONT_BIT]) exq.push_back({OP_STOP, 8'h00});
		apb(1'b1, OFS_REQ_CTRL, {20'h0, c, 4'h0, n});
	endtask

	task wait_done;
		do apb(1'b0, OFS_STATUS, 32'h0); while (q[ST_DONE_BIT] !== 1'b1);
		apb(1'b1, OFS_STATUS, 32'h2);
		while (exq.size() != 0) @(posedge clk_i);
		@(posedge clk_i);
	endtask

	// ==========================================================================
	// Bridged bus partner and operation monitor.
	always @(posedge clk_i) begin
		if (reset_i) begin
			rdata <= 8'h5A;
		end else if (op_valid && op_ready) begin
			if (op_code == OP_RDATA) rdq.push_back(rdata);
			chk("op", {op_code, (op_code == OP_DEVAD || op_code == OP_WDATA) ? op_data : 8'h00},
				exq.pop_front());
			if (op_code == OP_RDATA) rdata <= rdata + 8'h3B;
		end
		op_ready <= ($urandom % 4) != 0;
	end

	// ==========================================================================
	// Main sequence.
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		reset_i = 1'b1;
		void'($urandom(78));
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", q, 32'h0);
		apb(1'b0, OFS_TGT_ADDR, 32'h0);
		chk("addr", q, {24'h0, TGT_ADDR_RST});
		apb(1'b0, 12'h1F0, 32'h0);
		chk("slverr", e, 1'b1);
		xfer(CMD_WRITE_CONT, 4'h3, 8'h50, 1'b1);
		wait_done;
		chk("open", bus_open, 1'b1);
		xfer(CMD_WRITE_CONT, 4'h2, 8'h50, 1'b0);
		wait_done;
		xfer(CMD_WRITE, 4'h1, 8'h50, 1'b0);
		wait_done;
		chk("open", bus_open, 1'b0);
		xfer(CMD_WRITE, 4'h2, 8'h33, 1'b1);
		apb(1'b1, OFS_REQ_CTRL, 32'h0000_0103);
		wait_done;
		xfer(CMD_WRITE, 4'h0, 8'h44, 1'b1);
		wait_done;
		apb(1'b1, OFS_REQ_CTRL, 32'h0000_0302);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("idle", q, 32'h0);
		xfer(CMD_READ_CONT, 4'h4, 8'h21, 1'b1);
		wait_done;
		xfer(CMD_READ, 4'hF, 8'h21, 1'b0);
		do apb(1'b0, OFS_STATUS, 32'h0); while (q[12:8] !== 5'h10);
		chk("busy", q[ST_BUSY_BIT], 1'b1);
		for (int i = 0; i < 19; i++) begin
			if (i == 16) wait_done;
			apb(1'b0, OFS_REPLY_DATA, 32'h0);
			chk("reply", q, {24'h0, rdq.pop_front()});
		end
		apb(1'b0, OFS_REPLY_DATA, 32'h0);
		chk("empty", q, 32'h0);
		chk("open", bus_open, 1'b0);
		chk("left", exq.size(), 32'h0);
		close_out;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		close_out;
	end
endmodule
